// >>> pmc_pkg.sv
// Package with constants and types shared by the power mode control ends
package pmc_pkg;
  localparam logic [7:0] PMC_POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] PMC_POWER_CONTROL_RESET = 8'h00;
  localparam int PMC_BIT_BAUD_DOUBLE = 7;
  localparam int PMC_BIT_AUX_RAM_OFF = 6;
  localparam int PMC_BIT_STROBE_SUPPRESS = 5;
  localparam int PMC_BIT_WDOG_UNLOCK = 4;
  localparam int PMC_BIT_SPARE_B = 3;
  localparam int PMC_BIT_SPARE_A = 2;
  localparam int PMC_BIT_DEEP_SLEEP = 1;
  localparam int PMC_BIT_LIGHT_SLEEP = 0;
  localparam int PMC_AUX_RAM_BYTES = 768;
  // Watchdog restart delay in machine cycles, one machine cycle is 12 clocks
  localparam int PMC_WDOG_RESTART_MC = 3;
  localparam int PMC_CLKS_PER_MC = 12;
  localparam logic [5:0] PMC_WDOG_RESTART_CLKS = 6'(PMC_WDOG_RESTART_MC * PMC_CLKS_PER_MC);
  // Least external reset length ending idle: 24 oscillator periods
  localparam int PMC_EXT_RESET_MIN_OSC = 24;
  localparam int PMC_CLK_PERIOD_NS = 10;
  localparam int PMC_PLL_RESET_MIN_NS = 1000;
  localparam int PMC_PLL_RESET_MIN_CLKS = (PMC_PLL_RESET_MIN_NS + PMC_CLK_PERIOD_NS - 1)
    / PMC_CLK_PERIOD_NS;
  localparam int PMC_PLL_RESTART_MS = 63;
  localparam int PMC_PLL_RESTART_CLKS = PMC_PLL_RESTART_MS * 1000000 / PMC_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PMC_RUN = 2'b00,
    PMC_IDLE = 2'b01,
    PMC_DOWN = 2'b10,
    PMC_RESTART = 2'b11
  } pmc_mode_e;
endpackage

// >>> pmc_if.sv
// Interface joining the power mode controller to the core and interrupt side
`timescale 1ns/100ps
`default_nettype none
interface pmc_if;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_rdata;
  logic wdog_load;
  logic wake_irq;
  logic idle_irq;
  logic blocked_by_prio;
  logic wdog_reset;
  logic ext_reset;
  logic cpu_halt;
  logic [1:0] mode;
  modport device (
    input sfr_addr, sfr_wdata, sfr_wr, sfr_rd, wdog_load, wake_irq, idle_irq,
    blocked_by_prio, wdog_reset, ext_reset,
    output sfr_rdata, cpu_halt, mode
  );
  modport core (
    output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, wdog_load, wake_irq, idle_irq,
    blocked_by_prio, wdog_reset, ext_reset,
    input sfr_rdata, cpu_halt, mode
  );
endinterface
`default_nettype wire

// >>> pmc_device.sv
// Power control register and idle / power-down sequencer
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pmc_device
  import pmc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  pmc_if.device bus,
  input wire logic wdog_enable_pin_n_i,
  input wire logic crystal_select_i,
  input wire logic keep_slow_osc_i,
  input wire logic ext_code_i,
  input wire logic addr_latch_strobe_i,
  input wire logic prog_store_strobe_i,
  input wire logic [7:0] port2_latch_i,
  input wire logic [7:0] port2_addr_i,
  output logic baud_double_o,
  output logic aux_ram_off_o,
  output logic watchdog_reload_unlock_o,
  output logic addr_latch_strobe_o,
  output logic prog_store_strobe_o,
  output logic [7:0] port2_o,
  output logic port0_float_o,
  output logic i2c_float_o,
  output logic pwm_high_o,
  output logic timer2_reset_o,
  output logic adc_abort_o,
  output logic sys_clk_stop_o,
  output logic hf_osc_stop_o,
  output logic slow_osc_run_o
);
  typedef struct packed {
    logic [7:0] power_control;
    pmc_mode_e mode;
    logic [5:0] restart_cnt;
    logic [7:0] rdata;
    logic [1:0] ew_sync;
  } pmc_state_s;

  pmc_state_s st;
  pmc_state_s next_st;
  logic ew_high;
  logic [7:0] wr_val;

  assign ew_high = st.ew_sync[1];

  always_comb
  begin
    next_st = st;
    wr_val = bus.sfr_wdata;
    next_st.ew_sync = {st.ew_sync[0], wdog_enable_pin_n_i};
    next_st.rdata = 8'h00;
    if (bus.sfr_rd && bus.sfr_addr == PMC_POWER_CONTROL_ADDR)
    begin
      next_st.rdata = st.power_control;
    end
    if (bus.sfr_wr && bus.sfr_addr == PMC_POWER_CONTROL_ADDR)
    begin
      // Power-down refused while the watchdog pin enables it
      if (!ew_high)
      begin
        wr_val[PMC_BIT_DEEP_SLEEP] = st.power_control[PMC_BIT_DEEP_SLEEP];
      end
      next_st.power_control = wr_val;
    end
    if (bus.wdog_load)
    begin
      next_st.power_control[PMC_BIT_WDOG_UNLOCK] = 1'b0;
    end
    unique case (st.mode)
      PMC_RUN:
      begin
        if (st.power_control[PMC_BIT_DEEP_SLEEP])
        begin
          next_st.mode = PMC_DOWN;
        end
        else if (st.power_control[PMC_BIT_LIGHT_SLEEP])
        begin
          next_st.mode = PMC_IDLE;
        end
      end
      PMC_IDLE:
      begin
        if (bus.idle_irq && !bus.blocked_by_prio)
        begin
          next_st.power_control[PMC_BIT_LIGHT_SLEEP] = 1'b0;
          next_st.mode = PMC_RUN;
        end
      end
      PMC_DOWN:
      begin
        // Wake keeps SFRs and RAM untouched except the power-down bit and, when blocked, the idle bit
        if (bus.wake_irq)
        begin
          next_st.power_control[PMC_BIT_DEEP_SLEEP] = 1'b0;
          if (bus.blocked_by_prio)
          begin
            next_st.power_control[PMC_BIT_LIGHT_SLEEP] = 1'b1;
            next_st.mode = PMC_IDLE;
          end
          else
          begin
            next_st.mode = PMC_RUN;
          end
        end
      end
      PMC_RESTART:
      begin
        if (st.restart_cnt == 6'h00)
        begin
          next_st.mode = PMC_RUN;
        end
        else
        begin
          next_st.restart_cnt = st.restart_cnt - 6'h01;
        end
      end
    endcase
    // Watchdog reset clears SFRs and restarts after three machine cycles
    if (bus.wdog_reset)
    begin
      next_st.power_control = PMC_POWER_CONTROL_RESET;
      next_st.mode = PMC_RESTART;
      next_st.restart_cnt = PMC_WDOG_RESTART_CLKS - 6'h01;
    end
    // External reset clears SFRs; RAM lives outside this block
    if (bus.ext_reset)
    begin
      next_st.power_control = PMC_POWER_CONTROL_RESET;
      next_st.mode = PMC_RUN;
      next_st.restart_cnt = 6'h00;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st.power_control <= PMC_POWER_CONTROL_RESET;
      st.mode <= PMC_RUN;
      st.restart_cnt <= 6'h00;
      st.rdata <= 8'h00;
      st.ew_sync <= 2'b00;
    end
    else
    begin
      st <= next_st;
    end
  end

  logic idle_m;
  logic down_m;
  assign idle_m = (st.mode == PMC_IDLE);
  assign down_m = (st.mode == PMC_DOWN);

  assign bus.sfr_rdata = st.rdata;
  assign bus.mode = st.mode;
  // CPU frozen, its state held by the halt
  assign bus.cpu_halt = idle_m || down_m || st.mode == PMC_RESTART;
  assign baud_double_o = st.power_control[PMC_BIT_BAUD_DOUBLE];
  assign aux_ram_off_o = st.power_control[PMC_BIT_AUX_RAM_OFF];
  assign watchdog_reload_unlock_o = st.power_control[PMC_BIT_WDOG_UNLOCK];
  always_comb
  begin
    if (down_m)
    begin
      addr_latch_strobe_o = 1'b0;
      prog_store_strobe_o = 1'b0;
    end
    else if (idle_m)
    begin
      addr_latch_strobe_o = 1'b1;
      prog_store_strobe_o = 1'b1;
    end
    else
    begin
      addr_latch_strobe_o = addr_latch_strobe_i && !st.power_control[PMC_BIT_STROBE_SUPPRESS];
      prog_store_strobe_o = prog_store_strobe_i;
    end
  end
  // Port 2 shows latch data in power-down, address otherwise when external
  assign port2_o = (ext_code_i && !down_m) ? port2_addr_i : port2_latch_i;
  assign port0_float_o = ext_code_i && (idle_m || down_m);
  assign i2c_float_o = down_m;
  assign pwm_high_o = idle_m || down_m;
  assign timer2_reset_o = idle_m;
  assign adc_abort_o = idle_m;
  assign sys_clk_stop_o = down_m;
  assign hf_osc_stop_o = down_m || !crystal_select_i;
  assign slow_osc_run_o = !crystal_select_i && (!down_m || keep_slow_osc_i);
endmodule
`default_nettype wire

// >>> pmc_core.sv
// Core and interrupt side end driving the power mode controller
`timescale 1ns/100ps
`default_nettype none
module pmc_core
  import pmc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  pmc_if.core bus,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic wdog_load_i,
  input wire logic ext_irq_0_n_i,
  input wire logic ext_irq_1_n_i,
  input wire logic secs_irq_i,
  input wire logic other_irq_i,
  input wire logic blocked_i,
  input wire logic wdog_reset_i,
  input wire logic ext_reset_i,
  output logic [7:0] sfr_rdata_o,
  output logic halted_o
);
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic load;
    logic unlock;
    logic [1:0] irq0_sync;
    logic [1:0] irq1_sync;
    logic [1:0] rst_sync;
  } pmc_core_s;

  pmc_core_s st;
  pmc_core_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.addr = sfr_addr_i;
    next_st.wdata = sfr_wdata_i;
    next_st.wr = sfr_wr_i;
    next_st.rd = sfr_rd_i;
    // Watchdog load only passed on once unlocked
    next_st.load = wdog_load_i && st.unlock;
    // Unlock follows the last power control register write; a watchdog load clears it
    if (wdog_load_i)
    begin
      next_st.unlock = 1'b0;
    end
    else if (sfr_wr_i && sfr_addr_i == PMC_POWER_CONTROL_ADDR)
    begin
      next_st.unlock = sfr_wdata_i[PMC_BIT_WDOG_UNLOCK];
    end
    next_st.irq0_sync = {st.irq0_sync[0], ext_irq_0_n_i};
    next_st.irq1_sync = {st.irq1_sync[0], ext_irq_1_n_i};
    next_st.rst_sync = {st.rst_sync[0], ext_reset_i};
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st <= '0;
      // Start at the idle pin level, so no false wake follows reset
      st.irq0_sync <= '1;
      st.irq1_sync <= '1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus.sfr_addr = st.addr;
  assign bus.sfr_wdata = st.wdata;
  assign bus.sfr_wr = st.wr;
  assign bus.sfr_rd = st.rd;
  assign bus.wdog_load = st.load;
  // Level-low external or seconds wake sources
  assign bus.wake_irq = !st.irq0_sync[1] || !st.irq1_sync[1] || secs_irq_i;
  assign bus.idle_irq = bus.wake_irq || other_irq_i;
  assign bus.blocked_by_prio = blocked_i;
  assign bus.wdog_reset = wdog_reset_i;
  assign bus.ext_reset = st.rst_sync[1];
  assign sfr_rdata_o = bus.sfr_rdata;
  assign halted_o = bus.cpu_halt;
endmodule
`default_nettype wire

// >>> pmc_sva.sv
// Assertions on the interface joining the two power mode control ends
`timescale 1ns/100ps
`default_nettype none
module pmc_sva
  import pmc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic wake_irq,
  input wire logic idle_irq,
  input wire logic blocked_by_prio,
  input wire logic wdog_reset,
  input wire logic ext_reset,
  input wire logic cpu_halt,
  input wire logic [1:0] mode
);
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  logic rst_any;
  assign rst_any = wdog_reset || ext_reset;
  a_rdata_quiet: assert property (
    !$past(sfr_rd) |-> sfr_rdata == 8'h00) else $error("read data outside read cycle");
  a_sleep_halts: assert property (
    mode == PMC_IDLE || mode == PMC_DOWN |-> cpu_halt) else $error("cpu runs in sleep");
  a_idle_entry: assert property (
    sfr_wr && sfr_addr == PMC_POWER_CONTROL_ADDR && sfr_wdata[1:0] == 2'b01
    && mode == PMC_RUN && !rst_any ##1 !idle_irq && !rst_any |=> mode == PMC_IDLE)
    else $error("idle not entered");
  a_idle_wake: assert property (
    mode == PMC_IDLE && idle_irq && !blocked_by_prio && !rst_any |-> ##[1:2] mode == PMC_RUN)
    else $error("idle not ended by interrupt");
  a_idle_hold: assert property (
    mode == PMC_IDLE && (!idle_irq || blocked_by_prio) && !rst_any |=> mode == PMC_IDLE)
    else $error("idle left without cause");
  a_restart_len: assert property (
    $rose(mode == PMC_RESTART) |-> ##[34:38] mode == PMC_RUN) else $error("restart length");
  a_down_wake: assert property (
    mode == PMC_DOWN && wake_irq && !blocked_by_prio && !rst_any |-> ##[1:2] mode == PMC_RUN)
    else $error("power-down not woken");
  a_down_to_idle: assert property (
    mode == PMC_DOWN && wake_irq && blocked_by_prio && !rst_any |-> ##[1:2] mode == PMC_IDLE)
    else $error("blocked wake not idle");
  a_ext_reset_run: assert property (
    ext_reset && !wdog_reset |-> ##[1:2] mode == PMC_RUN) else $error("reset not run");
endmodule
`default_nettype wire

// >>> test_power_mode_control.sv
// Self-checking bench driving both power mode control ends
`timescale 1ns/100ps
`default_nettype none
module test_power_mode_control import pmc_pkg::*;;
  logic core_clk_i = 1'b0;
  logic srst_i, sfr_wr_i, sfr_rd_i, wdog_load_i, ext_irq_0_n_i, ext_irq_1_n_i, halted_o;
  logic secs_irq_i, other_irq_i, blocked_i, wdog_reset_i, ext_reset_i, ext_code_i;
  logic wdog_enable_pin_n_i, crystal_select_i, keep_slow_osc_i, prog_store_strobe_i;
  logic addr_latch_strobe_i, baud_double_o, aux_ram_off_o, watchdog_reload_unlock_o;
  logic addr_latch_strobe_o, prog_store_strobe_o, port0_float_o, i2c_float_o, pwm_high_o;
  logic timer2_reset_o, adc_abort_o, sys_clk_stop_o, hf_osc_stop_o, slow_osc_run_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, port2_latch_i, port2_addr_i, port2_o, v;
  // Last row writes a refused power-down bit
  logic [7:0] wv [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0c, 8'hfe};
  logic [7:0] ev [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0c, 8'hfc};
  int bad_count = 0;
  int compares = 0;
  pmc_if pmc_if_i();
  pmc_device pmc_device_i(.core_clk_i, .srst_i, .bus(pmc_if_i), .wdog_enable_pin_n_i,
    .crystal_select_i, .keep_slow_osc_i, .ext_code_i, .addr_latch_strobe_i,
    .prog_store_strobe_i, .port2_latch_i, .port2_addr_i, .baud_double_o, .aux_ram_off_o,
    .watchdog_reload_unlock_o, .addr_latch_strobe_o, .prog_store_strobe_o, .port2_o,
    .port0_float_o, .i2c_float_o, .pwm_high_o, .timer2_reset_o, .adc_abort_o,
    .sys_clk_stop_o, .hf_osc_stop_o, .slow_osc_run_o);
  pmc_core pmc_core_i(.core_clk_i, .srst_i, .bus(pmc_if_i), .sfr_addr_i, .sfr_wdata_i,
    .sfr_wr_i, .sfr_rd_i, .wdog_load_i, .ext_irq_0_n_i, .ext_irq_1_n_i, .secs_irq_i,
    .other_irq_i, .blocked_i, .wdog_reset_i, .ext_reset_i, .sfr_rdata_o, .halted_o);
  pmc_sva pmc_sva_i(.core_clk_i, .srst_i, .sfr_addr(pmc_if_i.sfr_addr),
    .sfr_wdata(pmc_if_i.sfr_wdata), .sfr_wr(pmc_if_i.sfr_wr), .sfr_rd(pmc_if_i.sfr_rd),
    .sfr_rdata(pmc_if_i.sfr_rdata), .wake_irq(pmc_if_i.wake_irq),
    .idle_irq(pmc_if_i.idle_irq), .blocked_by_prio(pmc_if_i.blocked_by_prio),
    .wdog_reset(pmc_if_i.wdog_reset), .ext_reset(pmc_if_i.ext_reset),
    .cpu_halt(pmc_if_i.cpu_halt), .mode(pmc_if_i.mode));
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) addr_latch_strobe_i <= ~addr_latch_strobe_i;
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic wr(logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i <= PMC_POWER_CONTROL_ADDR;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  // Core and device stages: data stands between the third and fourth edge
  task automatic rd(logic [7:0] a);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_i <= 1'b0;
    cyc(2);
    v = sfr_rdata_o;
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wh(logic h);
    for (int i = 0; i < 300 && halted_o !== h; i++)
      @(posedge core_clk_i);
    if (halted_o !== h)
    begin
      bad_count++;
      $display("BAD halt expected %h seen %h", h, halted_o);
      end_of_test();
    end
  endtask
  initial
  begin
    {sfr_wr_i, sfr_rd_i, wdog_load_i, secs_irq_i, other_irq_i, blocked_i} = '0;
    {wdog_reset_i, ext_reset_i, keep_slow_osc_i, ext_code_i, wdog_enable_pin_n_i} = '0;
    {srst_i, ext_irq_0_n_i, ext_irq_1_n_i, crystal_select_i, prog_store_strobe_i} = '1;
    {addr_latch_strobe_i, sfr_addr_i, sfr_wdata_i} = '0;
    port2_latch_i = 8'ha5;
    port2_addr_i = 8'h3c;
    cyc(4);
    srst_i <= 1'b0;
    rd(PMC_POWER_CONTROL_ADDR);
    chk("reset", v, PMC_POWER_CONTROL_RESET);
    chk("ale_run", addr_latch_strobe_o, addr_latch_strobe_i);
    cyc(1);
    chk("ale_run", addr_latch_strobe_o, addr_latch_strobe_i);
    for (int r = 0; r < 6; r++)
    begin
      wr(wv[r]);
      rd(PMC_POWER_CONTROL_ADDR);
      chk("power_control", v, ev[r]);
      chk("baud", baud_double_o, ev[r][7]);
      chk("aux", aux_ram_off_o, ev[r][6]);
      chk("unlock", watchdog_reload_unlock_o, ev[r][4]);
    end
    rd(8'h86);
    chk("unmapped", v, 8'h00);
    chk("ale_quiet", addr_latch_strobe_o, 8'h00);
    wdog_enable_pin_n_i <= 1'b1;
    cyc(1);
    chk("ale_quiet", addr_latch_strobe_o, 8'h00);
    wr(8'h10);
    wdog_load_i <= 1'b1;
    cyc(1);
    wdog_load_i <= 1'b0;
    rd(PMC_POWER_CONTROL_ADDR);
    chk("wle", v, 8'h00);
    wr(8'h05);
    wh(1'b1);
    chk("idle", {addr_latch_strobe_o, prog_store_strobe_o, pwm_high_o}, 8'h07);
    chk("stop", {timer2_reset_o, adc_abort_o}, 8'h03);
    blocked_i <= 1'b1;
    other_irq_i <= 1'b1;
    cyc(8);
    chk("blocked", halted_o, 8'h01);
    blocked_i <= 1'b0;
    wh(1'b0);
    other_irq_i <= 1'b0;
    rd(PMC_POWER_CONTROL_ADDR);
    chk("flags", v, 8'h04);
    ext_code_i <= 1'b1;
    wr(8'h06);
    wh(1'b1);
    chk("clocks", {sys_clk_stop_o, hf_osc_stop_o, slow_osc_run_o}, 8'h06);
    chk("pins", {addr_latch_strobe_o, prog_store_strobe_o, i2c_float_o}, 8'h01);
    chk("float", {pwm_high_o, port0_float_o}, 8'h03);
    chk("port2", port2_o, 8'ha5);
    ext_irq_0_n_i <= 1'b0;
    wh(1'b0);
    ext_irq_0_n_i <= 1'b1;
    rd(PMC_POWER_CONTROL_ADDR);
    chk("keep", v, 8'h04);
    chk("port2_run", port2_o, 8'h3c);
    crystal_select_i <= 1'b0;
    keep_slow_osc_i <= 1'b1;
    wr(8'h02);
    wh(1'b1);
    chk("slow", slow_osc_run_o, 8'h01);
    blocked_i <= 1'b1;
    secs_irq_i <= 1'b1;
    cyc(8);
    chk("to_idle", {halted_o, sys_clk_stop_o, addr_latch_strobe_o}, 8'h05);
    ext_reset_i <= 1'b1;
    cyc(120);
    {ext_reset_i, secs_irq_i, blocked_i} <= '0;
    wh(1'b0);
    rd(PMC_POWER_CONTROL_ADDR);
    chk("sfr_clr", v, 8'h00);
    wr(8'h09);
    wh(1'b1);
    wdog_reset_i <= 1'b1;
    cyc(1);
    wdog_reset_i <= 1'b0;
    cyc(2);
    chk("restart", halted_o, 8'h01);
    wh(1'b0);
    rd(PMC_POWER_CONTROL_ADDR);
    chk("wdog", v, 8'h00);
    wr(8'h20);
    rd(PMC_POWER_CONTROL_ADDR);
    chk("suppress", v, 8'h20);
    srst_i <= 1'b1;
    cyc(4);
    srst_i <= 1'b0;
    rd(PMC_POWER_CONTROL_ADDR);
    chk("rst_clear", v, PMC_POWER_CONTROL_RESET);
    end_of_test();
  end
endmodule
`default_nettype wire
